/* design/csi_cfg_pkg.sv */
// constants, field layouts and carriers of the csi-2 output config block
// assumes an apb master on the same clock as the block
//
// Functional notes
// - the fifth and sixth id bytes read back at main offsets f4/f5 and ignore writes.
// - trail override bit 7 low means automatic trail timing, high means bits 3:0 are used.
// - alignment bit 4 puts raw pixels on the low bits when 0 and the high bits when 1.
// - port 0 enable field resets to 3f, 00 disables the port and 3f enables it.
// - port 1 enable field resets to 00, 00 keeps the port off and 3f enables it.
// - bit 7 of each port enable register is register control, reset 0, 1 enables it.
// - pass routing bit 2, reset 0, drives the pass status out on general pin three.
// - pass routing bit 1, reset 1, drives the pass status out on general pin zero.
// - pass routing bit 0 reads back the live pass status.
// - the 2-bit field in bits 7:6, reset 00, is the virtual channel tag 0 to 3.
// - read-only registers ignore writes, read/write ones return what was written, except pass routing bit 0.
package csi_cfg_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // main map indices, byte address is four times the index
  localparam logic [7:0] IDX_IND_ADDR = 8'hb0;
  localparam logic [7:0] IDX_IND_DATA = 8'hb1;
  localparam logic [7:0] IDX_ID_FIVE = 8'hf4;
  localparam logic [7:0] IDX_ID_SIX = 8'hf5;
  localparam logic [ADDR_W-1:0] ADDR_IND_ADDR = {IDX_IND_ADDR, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IND_DATA = {IDX_IND_DATA, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ID_FIVE = {IDX_ID_FIVE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ID_SIX = {IDX_ID_SIX, 2'b00};

  // ------------------------------------------------------------------
  // indirect registers: slot, offset, reset value
  // ------------------------------------------------------------------
  localparam int N_IND = 6;
  localparam int R_TRAIL = 0;
  localparam int R_RAW = 1;
  localparam int R_EN0 = 2;
  localparam int R_EN1 = 3;
  localparam int R_PASS = 4;
  localparam int R_VC = 5;
  localparam logic [7:0] IND_IDX [N_IND] =
    '{8'h02, 8'h09, 8'h13, 8'h14, 8'h16, 8'h2e};
  localparam logic [7:0] IND_RST [N_IND] =
    '{8'h00, 8'h00, 8'h3f, 8'h00, 8'h02, 8'h00};

  // ------------------------------------------------------------------
  // field positions and codes
  // ------------------------------------------------------------------
  localparam int BIT_TRAIL_OV = 7;
  localparam int TRAIL_W = 4;
  localparam int BIT_RAW_MSB = 4;
  localparam int BIT_REG_CTL = 7;
  localparam int EN_W = 6;
  localparam logic [EN_W-1:0] EN_ON = 6'h3f;
  localparam logic [EN_W-1:0] EN_OFF = 6'h00;
  localparam int BIT_PASS_PIN3 = 2;
  localparam int BIT_PASS_PIN0 = 1;
  localparam int BIT_PASS_LIVE = 0;
  localparam int VC_LSB = 6;
  localparam int VC_W = 2;
  localparam int DT_W = 6;
  localparam logic [TRAIL_W-1:0] TRAIL_AUTO_BASE = 4'h3;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic [3:0] strb;
  } apb_req_t;

  typedef struct packed {
    logic trail_ov;
    logic [TRAIL_W-1:0] trail_val;
    logic raw_msb;
    logic [VC_W-1:0] vc;
  } cfg_t;

endpackage

/* design/csi_cfg_apb.sv */
// apb slave front end: zero wait states, registered answer
// assumes the decode of the parent arrives combinationally from req
`timescale 1ns/100ps
module csi_cfg_apb (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csi_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [csi_cfg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [csi_cfg_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // towards the register file
  input wire logic [csi_cfg_pkg::DATA_W-1:0] rdata,
  input wire logic mapped,
  output csi_cfg_pkg::apb_req_t req,
  output logic setup,
  output logic commit
);

  assign req = '{addr: paddr, write: pwrite, wdata: pwdata, strb: pstrb};
  assign setup = psel & ~penable;
  assign commit = psel & penable & pready;

  // answer is captured in setup so the access phase ends in one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? '0 : rdata;
      end
    end
  end

endmodule

/* design/csi_cfg_datapath.sv */
// trail timing select, raw alignment and virtual channel tagging
// assumes pixel and packet inputs come from logic on the same clock
`timescale 1ns/100ps
module csi_cfg_datapath #(
  parameter int RAW_W = 12,
  parameter int RGB_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration
  input csi_cfg_pkg::cfg_t cfg,
  input wire logic [csi_cfg_pkg::TRAIL_W-1:0] rate_code,
  // raw pixels in, bus out
  input wire logic [RAW_W-1:0] raw_pixel,
  input wire logic raw_valid,
  output logic [RGB_W-1:0] rgb_bus,
  output logic rgb_valid,
  // packet header tagging
  input wire logic [csi_cfg_pkg::DT_W-1:0] pkt_type,
  input wire logic pkt_valid,
  output logic [7:0] pkt_id,
  output logic pkt_id_valid,
  // trail timing in use
  output logic [csi_cfg_pkg::TRAIL_W-1:0] trail_eff
);

  if (RAW_W < 1 || RAW_W >= RGB_W) begin : g_bad_width
    $error("raw width must be below rgb bus width");
  end

  logic [csi_cfg_pkg::TRAIL_W-1:0] auto_trail;
  logic [csi_cfg_pkg::TRAIL_W-1:0] next_trail;
  logic [RGB_W-1:0] raw_low;
  logic [RGB_W-1:0] raw_high;
  logic [RGB_W-1:0] next_rgb;

  // automatic trail is the base 3 plus the lane rate code, wrapping at four bits
  assign auto_trail = csi_cfg_pkg::TRAIL_W'(
    csi_cfg_pkg::TRAIL_AUTO_BASE + rate_code);
  assign next_trail = cfg.trail_ov ? cfg.trail_val : auto_trail;
  assign raw_low = RGB_W'(raw_pixel);
  assign raw_high = {raw_pixel, {(RGB_W - RAW_W){1'b0}}};
  assign next_rgb = cfg.raw_msb ? raw_high : raw_low;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trail_eff <= '0;
      rgb_bus <= '0;
      rgb_valid <= 1'b0;
    end else begin
      trail_eff <= next_trail;
      rgb_valid <= raw_valid;
      if (raw_valid) begin
        rgb_bus <= next_rgb;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pkt_id <= '0;
      pkt_id_valid <= 1'b0;
    end else begin
      pkt_id_valid <= pkt_valid;
      if (pkt_valid) begin
        pkt_id <= {cfg.vc, pkt_type};
      end
    end
  end

endmodule

/* design/csi_cfg_top.sv */
// csi-2 output configuration registers behind an apb slave
// assumes pass status, pixels and packets arrive on clk; pins are outputs
`timescale 1ns/100ps
module csi_cfg_top #(
  parameter int RAW_W = 12,
  parameter int RGB_W = 24,
  // arbitrary identification values
  parameter logic [7:0] ID_FIVE = 8'h5a,
  parameter logic [7:0] ID_SIX = 8'hc3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csi_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [csi_cfg_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [csi_cfg_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // status and timing inputs
  input wire logic pass_status,
  input wire logic [csi_cfg_pkg::TRAIL_W-1:0] rate_code,
  // raw pixel path
  input wire logic [RAW_W-1:0] raw_pixel,
  input wire logic raw_valid,
  output logic [RGB_W-1:0] rgb_bus,
  output logic rgb_valid,
  // packet tagging
  input wire logic [csi_cfg_pkg::DT_W-1:0] pkt_type,
  input wire logic pkt_valid,
  output logic [7:0] pkt_id,
  output logic pkt_id_valid,
  // port control
  output logic port_a_enable,
  output logic port_b_enable,
  output logic port_a_register_control,
  output logic port_b_register_control,
  output logic [csi_cfg_pkg::TRAIL_W-1:0] trail_eff,
  // general pins, output side only
  output logic general_pin_zero_out,
  output logic general_pin_zero_oe,
  output logic general_pin_three_out,
  output logic general_pin_three_oe
);

  // ------------------------------------------------------------------
  // bus front end
  // ------------------------------------------------------------------
  csi_cfg_pkg::apb_req_t req;
  logic setup;
  logic commit;
  logic mapped;
  logic [csi_cfg_pkg::DATA_W-1:0] rdata;

  csi_cfg_apb u_apb (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .rdata(rdata),
    .mapped(mapped),
    .req(req),
    .setup(setup),
    .commit(commit)
  );

  // ------------------------------------------------------------------
  // main map decode
  // ------------------------------------------------------------------
  wire hit_ia = req.addr == csi_cfg_pkg::ADDR_IND_ADDR;
  wire hit_id = req.addr == csi_cfg_pkg::ADDR_IND_DATA;
  wire hit_id5 = req.addr == csi_cfg_pkg::ADDR_ID_FIVE;
  wire hit_id6 = req.addr == csi_cfg_pkg::ADDR_ID_SIX;
  wire wr_ok = commit & req.write & req.strb[0];
  wire wr_ia = wr_ok & hit_ia;
  wire wr_id = wr_ok & hit_id;
  wire [7:0] wbyte = req.wdata[7:0];
  assign mapped = hit_ia | hit_id | hit_id5 | hit_id6;

  // ------------------------------------------------------------------
  // indirect register file
  // ------------------------------------------------------------------
  logic [7:0] ind_addr;
  logic [7:0] ind_reg [csi_cfg_pkg::N_IND];
  logic [csi_cfg_pkg::N_IND-1:0] ind_sel;
  logic [7:0] ind_rd;
  logic [7:0] ind_live;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ind_addr <= '0;
    end else if (wr_ia) begin
      ind_addr <= wbyte;
    end
  end

  // undefined offsets select nothing: writes drop, reads give zero
  for (genvar i = 0; i < csi_cfg_pkg::N_IND; i++) begin : g_ind
    assign ind_sel[i] = ind_addr == csi_cfg_pkg::IND_IDX[i];
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        ind_reg[i] <= csi_cfg_pkg::IND_RST[i];
      end else if (wr_id && ind_sel[i]) begin
        ind_reg[i] <= wbyte;
      end
    end
  end

  always_comb begin
    ind_rd = '0;
    for (int k = 0; k < csi_cfg_pkg::N_IND; k++) begin
      ind_rd = ind_rd | (ind_sel[k] ? ind_reg[k] : 8'h00);
    end
  end

  // pass bit reads the live status, never the stored copy
  always_comb begin
    ind_live = ind_rd;
    if (ind_sel[csi_cfg_pkg::R_PASS]) begin
      ind_live[csi_cfg_pkg::BIT_PASS_LIVE] = pass_status;
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire [7:0] rd_byte = hit_ia ? ind_addr :
    hit_id ? ind_live :
    hit_id5 ? ID_FIVE :
    hit_id6 ? ID_SIX : 8'h00;
  assign rdata = csi_cfg_pkg::DATA_W'(rd_byte);

  // ------------------------------------------------------------------
  // named fields
  // ------------------------------------------------------------------
  wire [7:0] trail_r = ind_reg[csi_cfg_pkg::R_TRAIL];
  wire [7:0] en0_r = ind_reg[csi_cfg_pkg::R_EN0];
  wire [7:0] en1_r = ind_reg[csi_cfg_pkg::R_EN1];
  wire [7:0] pass_r = ind_reg[csi_cfg_pkg::R_PASS];
  wire [csi_cfg_pkg::EN_W-1:0] port_a_enable_field =
    en0_r[csi_cfg_pkg::EN_W-1:0];
  wire [csi_cfg_pkg::EN_W-1:0] port_b_enable_field =
    en1_r[csi_cfg_pkg::EN_W-1:0];
  wire pass_to_pin_three = pass_r[csi_cfg_pkg::BIT_PASS_PIN3];
  wire pass_to_pin_zero = pass_r[csi_cfg_pkg::BIT_PASS_PIN0];
  wire [csi_cfg_pkg::VC_W-1:0] virtual_channel_field =
    ind_reg[csi_cfg_pkg::R_VC][csi_cfg_pkg::VC_LSB +: csi_cfg_pkg::VC_W];

  csi_cfg_pkg::cfg_t cfg;
  assign cfg = '{
    trail_ov: trail_r[csi_cfg_pkg::BIT_TRAIL_OV],
    trail_val: trail_r[csi_cfg_pkg::TRAIL_W-1:0],
    raw_msb: ind_reg[csi_cfg_pkg::R_RAW][csi_cfg_pkg::BIT_RAW_MSB],
    vc: virtual_channel_field
  };

  // intermediate field codes count as off, only the full code enables
  wire next_a_en = port_a_enable_field == csi_cfg_pkg::EN_ON;
  wire next_b_en = port_b_enable_field == csi_cfg_pkg::EN_ON;

  // ------------------------------------------------------------------
  // port and pin outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_a_enable <= 1'b0;
      port_b_enable <= 1'b0;
      port_a_register_control <= 1'b0;
      port_b_register_control <= 1'b0;
    end else begin
      port_a_enable <= next_a_en;
      port_b_enable <= next_b_en;
      port_a_register_control <= en0_r[csi_cfg_pkg::BIT_REG_CTL];
      port_b_register_control <= en1_r[csi_cfg_pkg::BIT_REG_CTL];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      general_pin_zero_out <= 1'b0;
      general_pin_zero_oe <= 1'b0;
      general_pin_three_out <= 1'b0;
      general_pin_three_oe <= 1'b0;
    end else begin
      general_pin_zero_out <= pass_to_pin_zero & pass_status;
      general_pin_zero_oe <= pass_to_pin_zero;
      general_pin_three_out <= pass_to_pin_three & pass_status;
      general_pin_three_oe <= pass_to_pin_three;
    end
  end

  // ------------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------------
  csi_cfg_datapath #(
    .RAW_W(RAW_W),
    .RGB_W(RGB_W)
  ) u_dp (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg),
    .rate_code(rate_code),
    .raw_pixel(raw_pixel),
    .raw_valid(raw_valid),
    .rgb_bus(rgb_bus),
    .rgb_valid(rgb_valid),
    .pkt_type(pkt_type),
    .pkt_valid(pkt_valid),
    .pkt_id(pkt_id),
    .pkt_id_valid(pkt_id_valid),
    .trail_eff(trail_eff)
  );

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire rd_setup = setup & ~req.write;
  wire [7:0] vc_reg = ind_reg[csi_cfg_pkg::R_VC];

  sequence vc_write_s;
    wr_id && ind_sel[csi_cfg_pkg::R_VC];
  endsequence

  sequence vc_read_s;
    rd_setup && hit_id && ind_sel[csi_cfg_pkg::R_VC];
  endsequence

  ident_five_a: assert property (
    rd_setup && hit_id5 |=> prdata[7:0] == ID_FIVE && pready)
    else $error("ident byte five read wrong");
  ident_six_a: assert property (
    rd_setup && hit_id6 |=> prdata[7:0] == ID_SIX && !pslverr)
    else $error("ident byte six read wrong");
  trail_override_a: assert property (
    cfg.trail_ov |=> trail_eff == $past(cfg.trail_val))
    else $error("trail override value not used");
  raw_high_a: assert property (
    raw_valid && cfg.raw_msb |=>
      rgb_bus[RGB_W-1 -: RAW_W] == $past(raw_pixel) && rgb_valid)
    else $error("raw pixels not on high bits");
  port_a_on_a: assert property (
    port_a_enable_field == csi_cfg_pkg::EN_ON |=> port_a_enable)
    else $error("port a not enabled");
  port_b_off_a: assert property (
    port_b_enable_field == csi_cfg_pkg::EN_OFF |=> !port_b_enable)
    else $error("port b not disabled");
  reg_ctl_a: assert property (
    ##1 port_a_register_control == $past(en0_r[csi_cfg_pkg::BIT_REG_CTL]))
    else $error("register control not following field");
  pin_three_a: assert property (
    pass_to_pin_three && pass_status |=>
      general_pin_three_out && general_pin_three_oe)
    else $error("pass not on pin three");
  pin_zero_a: assert property (
    !pass_to_pin_zero |=> !general_pin_zero_oe && !general_pin_zero_out)
    else $error("pin zero driven while unrouted");
  pass_live_a: assert property (
    rd_setup && hit_id && ind_sel[csi_cfg_pkg::R_PASS] |=>
      prdata[0] == $past(pass_status))
    else $error("pass bit not live");
  vc_tag_a: assert property (
    pkt_valid |=> pkt_id[7:6] == $past(virtual_channel_field))
    else $error("virtual channel tag wrong");
  vc_store_a: assert property (
    vc_write_s |=> vc_reg == $past(wbyte))
    else $error("indirect write not stored");
  vc_readback_a: assert property (
    vc_read_s |=> prdata[7:0] == $past(vc_reg))
    else $error("indirect read mismatch");

endmodule

/* verification/csi_rx_model.sv */
// far-side receiver model: collects pixels and tagged packet headers
// assumes the block's outputs are registered on the same clock
`timescale 1ns/100ps
module csi_rx_model #(
  parameter int RGB_W = 24
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // from the block
  input wire logic [RGB_W-1:0] rgb_bus,
  input wire logic rgb_valid,
  input wire logic [7:0] pkt_id,
  input wire logic pkt_id_valid,
  // what arrived
  output logic [RGB_W-1:0] last_pix,
  output logic [7:0] last_id,
  output int n_pix,
  output int n_id
);
  // counts expose a valid that stays up for more than one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_pix <= '0;
      last_id <= '0;
      n_pix <= 0;
      n_id <= 0;
    end else begin
      if (rgb_valid) begin
        last_pix <= rgb_bus;
        n_pix <= n_pix + 1;
      end
      if (pkt_id_valid) begin
        last_id <= pkt_id;
        n_id <= n_id + 1;
      end
    end
  end
endmodule

/* verification/test_csi2_output_indirect_config.sv */
// self-checking bench for the csi-2 output config block
// assumes the apb slave, pixel path and pin outputs share one clock
`timescale 1ns/100ps
module test_csi2_output_indirect_config;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam logic [7:0] ID5 = 8'h6e; // arbitrary id value
  localparam logic [7:0] ID6 = 8'h91; // arbitrary id value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [csi_cfg_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic pass_status = 1'b0;
  logic [3:0] rate_code = '0;
  logic [11:0] raw_pixel = '0;
  logic raw_valid = 1'b0;
  logic [5:0] pkt_type = '0;
  logic pkt_valid = 1'b0;
  logic pready, pslverr, rgb_valid, pkt_id_valid;
  logic [31:0] prdata;
  logic [23:0] rgb_bus, last_pix;
  logic [7:0] pkt_id, last_id;
  logic port_a_enable, port_b_enable;
  logic port_a_register_control, port_b_register_control;
  logic [3:0] trail_eff;
  logic general_pin_zero_out, general_pin_zero_oe;
  logic general_pin_three_out, general_pin_three_oe;
  int n_pix, n_id;
  int err_total = 0;
  int checks_done = 0;
  int seed = 9;
  logic [7:0] sh [6];
  logic [31:0] rd, d;
  logic er;
  int s;

  always #50 clk = ~clk;

  csi_cfg_top #(.ID_FIVE(ID5), .ID_SIX(ID6)) DUT (.clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
    .pass_status, .rate_code, .raw_pixel, .raw_valid, .rgb_bus, .rgb_valid,
    .pkt_type, .pkt_valid, .pkt_id, .pkt_id_valid, .port_a_enable,
    .port_b_enable, .port_a_register_control, .port_b_register_control,
    .trail_eff, .general_pin_zero_out, .general_pin_zero_oe,
    .general_pin_three_out, .general_pin_three_oe);

  csi_rx_model rx (.clk, .rstn, .rgb_bus, .rgb_valid, .pkt_id,
    .pkt_id_valid, .last_pix, .last_id, .n_pix, .n_id);

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // idle edge first, so psel is never set twice in one step
  task automatic apb(input logic wr, input logic [9:0] a,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ind_wr(input logic [7:0] off, input logic [7:0] v,
                        input logic [3:0] st);
    apb(1'b1, csi_cfg_pkg::ADDR_IND_ADDR, {24'h0, off}, 4'hf);
    apb(1'b1, csi_cfg_pkg::ADDR_IND_DATA, {24'h0, v}, st);
  endtask

  task automatic ind_rd(input logic [7:0] off);
    apb(1'b1, csi_cfg_pkg::ADDR_IND_ADDR, {24'h0, off}, 4'hf);
    apb(1'b0, csi_cfg_pkg::ADDR_IND_DATA, 32'h0, 4'hf);
  endtask

  // the pass bit reads the live level, not the stored one
  function automatic logic [31:0] exp_rd(input int k);
    if (k == csi_cfg_pkg::R_PASS) begin
      return {24'h0, sh[k][7:1], pass_status};
    end
    return {24'h0, sh[k]};
  endfunction

  task automatic check_outs();
    logic [7:0] a, b, t, g;
    logic [3:0] te;
    a = sh[csi_cfg_pkg::R_EN0];
    b = sh[csi_cfg_pkg::R_EN1];
    t = sh[csi_cfg_pkg::R_TRAIL];
    g = sh[csi_cfg_pkg::R_PASS];
    te = t[7] ? t[3:0] : csi_cfg_pkg::TRAIL_AUTO_BASE + rate_code;
    check(32'(port_a_enable), 32'(a[5:0] == 6'h3f));
    check(32'(port_b_enable), 32'(b[5:0] == 6'h3f));
    check(32'({port_a_register_control, port_b_register_control}),
          32'({a[7], b[7]}));
    check(32'(trail_eff), 32'(te));
    check(32'({general_pin_zero_oe, general_pin_zero_out}),
          32'({g[1], g[1] & pass_status}));
    check(32'({general_pin_three_oe, general_pin_three_out}),
          32'({g[2], g[2] & pass_status}));
  endtask

  task automatic stream(input logic [11:0] p, input logic [5:0] t);
    int np, ni;
    np = n_pix;
    ni = n_id;
    @(posedge clk);
    raw_pixel <= p;
    raw_valid <= 1'b1;
    pkt_type <= t;
    pkt_valid <= 1'b1;
    @(posedge clk);
    raw_valid <= 1'b0;
    pkt_valid <= 1'b0;
    repeat (3) @(posedge clk);
    check({16'(n_pix - np), 16'(n_id - ni)}, 32'h0001_0001);
    check(32'(last_pix), 32'(sh[csi_cfg_pkg::R_RAW][4] ? {p, 12'h0}
          : {12'h0, p}));
    check(32'(last_id), 32'({sh[csi_cfg_pkg::R_VC][7:6], t}));
  endtask

  // every reset value read back; the trail, enable and pass ones also seen on the outputs
  task automatic check_reset();
    for (int i = 0; i < 6; i++) begin
      sh[i] = csi_cfg_pkg::IND_RST[i];
      ind_rd(csi_cfg_pkg::IND_IDX[i]);
      check(rd, exp_rd(i));
    end
    check_outs();
  endtask

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    check_reset();
    $display("test reset values done");
    for (int k = 0; k < 2; k++) begin
      d = $random(seed);
      apb(1'b1, k ? csi_cfg_pkg::ADDR_ID_SIX : csi_cfg_pkg::ADDR_ID_FIVE,
          d, 4'hf);
      check(32'(er), 32'h0);
      apb(1'b0, k ? csi_cfg_pkg::ADDR_ID_SIX : csi_cfg_pkg::ADDR_ID_FIVE,
          32'h0, 4'hf);
      check(rd, {24'h0, k ? ID6 : ID5});
    end
    apb(1'b0, 10'h100, 32'h0, 4'hf);
    check({rd[30:0], er}, 32'h1);
    ind_rd(8'h03); // undefined offset is only read
    check(rd, 32'h0);
    $display("test ident and refusals done");
    for (int i = 0; i < 48; i++) begin
      d = $random(seed);
      s = d[18:16] % 6;
      if (d[8]) begin
        d[5:0] = d[9] ? 6'h3f : 6'h00;
      end
      pass_status <= d[24];
      rate_code <= d[28:25];
      ind_wr(csi_cfg_pkg::IND_IDX[s], d[7:0], d[22:20] == 0 ? 4'h0 : 4'hf);
      if (d[22:20] != 0) begin
        sh[s] = d[7:0];
      end
      ind_rd(csi_cfg_pkg::IND_IDX[s]);
      check(rd, exp_rd(s));
      check_outs();
    end
    $display("test random register traffic done");
    for (int v = 0; v < 4; v++) begin
      d = $random(seed);
      sh[csi_cfg_pkg::R_VC] = {2'(v), d[5:0]};
      sh[csi_cfg_pkg::R_RAW] = {3'h0, v[0], d[3:0]};
      ind_wr(csi_cfg_pkg::IND_IDX[csi_cfg_pkg::R_VC],
             sh[csi_cfg_pkg::R_VC], 4'hf);
      ind_wr(csi_cfg_pkg::IND_IDX[csi_cfg_pkg::R_RAW],
             sh[csi_cfg_pkg::R_RAW], 4'hf);
      stream(d[19:8], d[25:20]);
    end
    $display("test pixel and packet path done");
    // reset after traffic must bring every register back
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    check_reset();
    $display("test reset in mid-run done");
    test_done();
  end
endmodule
